// ---- pkg/smp_regs.svh ----
`ifndef SMP_REGS_SVH
`define SMP_REGS_SVH

// ----------------------------------------------------------------
// Register map (APB byte offsets)
// ----------------------------------------------------------------
`define SMP_CTRL_OFF 12'h000
`define SMP_STAT_OFF 12'h004
`define SMP_CTRL_IRQ_EN_BIT 0
`define SMP_CTRL_RST 1'b0
`define SMP_STAT_MON_BIT 0
`define SMP_STAT_FORCED_BIT 1
`define SMP_STAT_UNLOCK_BIT 2
`define SMP_STAT_SECDONE_BIT 3
`define SMP_STAT_STATE_LSB 4

// ----------------------------------------------------------------
// Bit timing: divisors in bus clock cycles, delay and frame counts in bit times
// ----------------------------------------------------------------
`define SMP_BAUD_DIV_EXT 9'h100
`define SMP_BAUD_DIV_INT 9'h14F
`define SMP_CMD_DELAY_BITS 4'hB
`define SMP_TX_FRAME_SLOTS 4'hD

// ----------------------------------------------------------------
// Addresses and values
// ----------------------------------------------------------------
`define SMP_VEC_HI_ADDR 16'hFFFE
`define SMP_VEC_LO_ADDR 16'hFFFF
`define SMP_ERASED 8'hFF
`define SMP_SEC_BASE 16'hFFF6
`define SMP_SEC_LAST 3'h7
`define SMP_MON_VEC_PAGE 8'hFE
`define SMP_USER_VEC_PAGE 8'hFF
`define SMP_FLASH_BASE 16'h8000
`define SMP_INVALID_BYTE 8'hAD

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define SMP_OP_READ 8'h4A
`define SMP_OP_WRITE 8'h49
`define SMP_OP_INDEXED_READ_CMD 8'h1A
`define SMP_OP_INDEXED_WRITE_CMD 8'h19
`define SMP_OP_READ_STACK_POINTER_CMD 8'h0C
`define SMP_OP_RUN 8'h28

`endif

// ---- pkg/smp_pkg.sv ----
package smp_pkg;

	typedef enum logic [3:0] {
		ms_latch = 4'h0,
		ms_vec_hi = 4'h1,
		ms_vec_lo = 4'h2,
		ms_user = 4'h3,
		ms_sec_rx = 4'h4,
		ms_sec_cmp = 4'h5,
		ms_brk = 4'h6,
		ms_cmd = 4'h7,
		ms_wait = 4'h8,
		ms_mem = 4'h9,
		ms_cap = 4'hA,
		ms_reply = 4'hB,
		ms_run = 4'hC
	} smp_mode_e;

	typedef struct packed {
		smp_mode_e state;
		logic normal;
		logic forced;
		logic int_osc;
		logic sec_done;
		logic sec_ok;
		logic unlocked;
		logic cfg_rst;
		logic cfg_clk;
		logic irq_en;
		logic [7:0] vhi;
		logic [7:0] cmd;
		logic have;
		logic [1:0] need;
		logic [23:0] args;
		logic [15:0] ptr;
		logic [15:0] reply;
		logic two;
		logic [2:0] sec_idx;
		logic [8:0] dcnt;
		logic [3:0] dbits;
		logic rx_busy;
		logic rx_hi;
		logic [8:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [8:0] rx_sh;
		logic rx_done;
		logic rx_brk;
		logic tx_busy;
		logic [8:0] tx_cnt;
		logic [3:0] tx_left;
		logic [12:0] tx_sh;
		logic line_out;
		logic line_oe_n;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
		logic mem_we;
		logic mem_re;
		logic wdog_dis;
		logic rst_pin;
		logic clk_pin;
		logic br_en;
		logic pa2_zero;
		logic [7:0] vec_page;
		logic extra_rst;
		logic illegal_rst;
		logic software_interrupt;
		logic run;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} smp_state_s;

endpackage

// ---- logic/smp_monitor.sv ----
`timescale 1ns/1ps
`include "smp_regs.svh"

module smp_monitor (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial pin, open drain
	input wire logic serial_comm_pin_in,
	output logic serial_comm_pin_out,
	output logic serial_comm_pin_oe_n,
	// Mode pins and configuration
	input wire logic high_test_voltage,
	input wire logic irq_pin_level,
	input wire logic mode_select_pin_a,
	input wire logic mode_select_pin_b,
	input wire logic cfg_reset_pin_en,
	input wire logic cfg_clock_pin_en,
	input wire logic system_reset,
	input wire logic flash_fetch,
	input wire logic [15:0] cpu_sp,
	// Memory port, read data valid while mem_re is high
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [7:0] mem_rdata,
	// Chip control
	output logic watchdog_disable,
	output logic reset_capable_pin_is_reset,
	output logic clock_capable_pin_is_clock,
	output logic irq_branch_enable,
	output logic port_a_bit2_zero,
	output logic [7:0] vector_page,
	output logic extra_reset,
	output logic illegal_addr_reset,
	output logic monitor_swi,
	output logic run_request,
	output logic monitor_mode,
	output logic forced_monitor,
	output logic flash_unlocked
);

	smp_pkg::smp_state_s st_q;
	smp_pkg::smp_state_s st_d;

	// Returns {valid, argument byte count} for an opcode.
	function automatic logic [2:0] cmd_args(input logic [7:0] op);
		case (op)
			`SMP_OP_READ: cmd_args = 3'h6;
			`SMP_OP_WRITE: cmd_args = 3'h7;
			`SMP_OP_INDEXED_WRITE_CMD: cmd_args = 3'h5;
			`SMP_OP_INDEXED_READ_CMD, `SMP_OP_READ_STACK_POINTER_CMD, `SMP_OP_RUN: cmd_args = 3'h4;
			default: cmd_args = 3'h0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		smp_pkg::smp_state_s n;
		logic [8:0] div;
		logic mon;
		logic go;
		logic [12:0] frame;
		logic [2:0] ca;
		logic [15:0] a;
		n = st_q;
		div = (st_q.forced && st_q.int_osc) ? `SMP_BAUD_DIV_INT : `SMP_BAUD_DIV_EXT;
		mon = st_q.normal || st_q.forced;
		go = 1'b0;
		frame = 13'h1FFF;
		ca = 3'h0;
		a = 16'h0000;
		n.rx_done = 1'b0;
		n.rx_brk = 1'b0;
		n.mem_re = 1'b0;
		n.mem_we = 1'b0;
		n.extra_rst = 1'b0;
		n.illegal_rst = 1'b0;
		n.software_interrupt = 1'b0;
		n.run = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.line_out = 1'b0;

		// APB: zero wait states, answer in the access phase.
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			if (paddr == `SMP_CTRL_OFF) begin
				n.prdata[`SMP_CTRL_IRQ_EN_BIT] = st_q.irq_en;
			end else if (paddr == `SMP_STAT_OFF) begin
				n.prdata[`SMP_STAT_MON_BIT] = mon;
				n.prdata[`SMP_STAT_FORCED_BIT] = st_q.forced;
				n.prdata[`SMP_STAT_UNLOCK_BIT] = st_q.unlocked;
				n.prdata[`SMP_STAT_SECDONE_BIT] = st_q.sec_done;
				n.prdata[`SMP_STAT_STATE_LSB +: 4] = st_q.state;
			end else begin
				n.pslverr = 1'b1;
			end
		end
		if (psel && penable && st_q.pready && pwrite && !st_q.pslverr && paddr == `SMP_CTRL_OFF) begin
			n.irq_en = pwdata[`SMP_CTRL_IRQ_EN_BIT];
		end

		// pin setup frozen as high voltage drops
		// The registered watchdog disable is still high in the first cycle with the voltage off, so the copy is taken once.
		if (st_q.normal && !st_q.forced && st_q.wdog_dis && !high_test_voltage) begin
			n.cfg_rst = cfg_reset_pin_en;
			n.cfg_clk = cfg_clock_pin_en;
		end
		if (st_q.forced) begin
			n.rst_pin = 1'b0;
			n.clk_pin = irq_pin_level;
		end else if (st_q.normal) begin
			n.rst_pin = high_test_voltage ? 1'b1 : n.cfg_rst;
			n.clk_pin = high_test_voltage ? 1'b1 : n.cfg_clk;
		end else begin
			n.rst_pin = cfg_reset_pin_en;
			n.clk_pin = cfg_clock_pin_en;
		end
		n.wdog_dis = st_q.forced || (st_q.normal && high_test_voltage);
		n.br_en = st_q.forced || st_q.irq_en;
		n.pa2_zero = st_q.forced;
		n.vec_page = mon ? `SMP_MON_VEC_PAGE : `SMP_USER_VEC_PAGE;
		if (flash_fetch && mon && !st_q.unlocked) begin
			n.illegal_rst = 1'b1;
		end

		if (!st_q.rx_busy) begin
			n.rx_hi = serial_comm_pin_in;
			if (mon && !st_q.tx_busy && st_q.rx_hi && !serial_comm_pin_in) begin
				n.rx_busy = 1'b1;
				n.rx_cnt = div >> 1;
				n.rx_bits = 4'h0;
			end
		end else if (st_q.rx_cnt != 9'h000) begin
			n.rx_cnt = st_q.rx_cnt - 9'h001;
		end else begin
			n.rx_cnt = div - 9'h001;
			if (st_q.rx_bits == 4'h0 && serial_comm_pin_in) begin
				n.rx_busy = 1'b0;
			end else begin
				n.rx_bits = st_q.rx_bits + 4'h1;
				if (st_q.rx_bits != 4'h0) begin
					n.rx_sh = {serial_comm_pin_in, st_q.rx_sh[8:1]};
				end
				if (st_q.rx_bits == 4'h9) begin
					n.rx_busy = 1'b0;
					n.rx_hi = 1'b0;
					if (serial_comm_pin_in) begin
						n.rx_done = 1'b1;
					end else if (st_q.rx_sh[8:1] == 8'h00) begin
						n.rx_brk = 1'b1;
					end
				end
			end
		end

		if (mon && !st_q.tx_busy && (st_q.rx_done || st_q.rx_brk)) begin
			go = 1'b1;
			frame = st_q.rx_brk ? {1'b1, 9'h000, 1'b0, 2'b11} : {2'b11, st_q.rx_sh[7:0], 1'b0, 2'b11};
		end

		unique case (st_q.state)
			smp_pkg::ms_latch: begin
				n.normal = high_test_voltage && mode_select_pin_a && !mode_select_pin_b;
				n.int_osc = !irq_pin_level;
				n.mem_addr = `SMP_VEC_HI_ADDR;
				n.mem_re = 1'b1;
				n.state = smp_pkg::ms_vec_hi;
			end
			smp_pkg::ms_vec_hi: begin
				n.vhi = mem_rdata;
				n.mem_addr = `SMP_VEC_LO_ADDR;
				n.mem_re = 1'b1;
				n.state = smp_pkg::ms_vec_lo;
			end
			smp_pkg::ms_vec_lo: begin
				if (st_q.normal) begin
					n.software_interrupt = 1'b1;
					n.state = st_q.sec_done ? smp_pkg::ms_brk : smp_pkg::ms_sec_rx;
				end else if (st_q.vhi == `SMP_ERASED && mem_rdata == `SMP_ERASED) begin
					n.forced = 1'b1;
					n.extra_rst = 1'b1;
					n.software_interrupt = 1'b1;
					n.state = st_q.sec_done ? smp_pkg::ms_brk : smp_pkg::ms_sec_rx;
				end else begin
					n.state = smp_pkg::ms_user;
				end
			end
			smp_pkg::ms_user, smp_pkg::ms_run: begin
				n.state = st_q.state;
			end
			smp_pkg::ms_sec_rx: begin
				if (st_q.rx_done) begin
					n.args[7:0] = st_q.rx_sh[7:0];
					n.mem_addr = `SMP_SEC_BASE + {13'h0000, st_q.sec_idx};
					n.mem_re = 1'b1;
					n.state = smp_pkg::ms_sec_cmp;
				end
			end
			smp_pkg::ms_sec_cmp: begin
				n.sec_ok = st_q.sec_ok && (mem_rdata == st_q.args[7:0]);
				n.sec_idx = st_q.sec_idx + 3'h1;
				if (st_q.sec_idx == `SMP_SEC_LAST) begin
					n.unlocked = n.sec_ok;
					n.sec_done = 1'b1;
					n.state = smp_pkg::ms_brk;
				end else begin
					n.state = smp_pkg::ms_sec_rx;
				end
			end
			smp_pkg::ms_brk: begin
				if (!st_q.tx_busy && !go) begin
					go = 1'b1;
					frame = {1'b1, 9'h000, 1'b0, 2'b11};
					n.have = 1'b0;
					n.state = smp_pkg::ms_cmd;
				end
			end
			smp_pkg::ms_cmd: begin
				if (st_q.rx_done) begin
					if (!st_q.have) begin
						ca = cmd_args(st_q.rx_sh[7:0]);
						n.cmd = st_q.rx_sh[7:0];
						n.have = ca[2] && (ca[1:0] != 2'h0);
						n.need = ca[1:0];
						if (ca[2] && ca[1:0] == 2'h0) begin
							n.state = smp_pkg::ms_wait;
						end
					end else begin
						n.args = {st_q.args[15:0], st_q.rx_sh[7:0]};
						n.need = st_q.need - 2'h1;
						if (st_q.need == 2'h1) begin
							n.have = 1'b0;
							n.state = smp_pkg::ms_wait;
						end
					end
					n.dbits = `SMP_CMD_DELAY_BITS;
					n.dcnt = div - 9'h001;
				end
			end
			smp_pkg::ms_wait: begin
				if (st_q.rx_brk) begin
					n.state = smp_pkg::ms_cmd;
				end else if (st_q.tx_busy) begin
					// The receiver is deaf while the echo is on the wire, so the window opens after it.
					n.dcnt = div - 9'h001;
				end else if (st_q.dcnt != 9'h000) begin
					n.dcnt = st_q.dcnt - 9'h001;
				end else if (st_q.dbits == 4'h1) begin
					n.state = smp_pkg::ms_mem;
				end else begin
					n.dbits = st_q.dbits - 4'h1;
					n.dcnt = div - 9'h001;
				end
			end
			smp_pkg::ms_mem: begin
				n.state = smp_pkg::ms_cmd;
				a = st_q.ptr + 16'h0001;
				if (st_q.cmd == `SMP_OP_READ) begin
					a = st_q.args[15:0];
				end else if (st_q.cmd == `SMP_OP_WRITE) begin
					a = st_q.args[23:8];
				end
				if (st_q.cmd == `SMP_OP_READ || st_q.cmd == `SMP_OP_INDEXED_READ_CMD) begin
					n.ptr = a;
					n.mem_addr = a;
					n.mem_re = 1'b1;
					n.state = smp_pkg::ms_cap;
				end else if (st_q.cmd == `SMP_OP_WRITE || st_q.cmd == `SMP_OP_INDEXED_WRITE_CMD) begin
					n.ptr = a;
					n.mem_addr = a;
					n.mem_wdata = st_q.args[7:0];
					n.mem_we = 1'b1;
				end else if (st_q.cmd == `SMP_OP_READ_STACK_POINTER_CMD) begin
					n.reply = cpu_sp + 16'h0001;
					n.two = 1'b1;
					n.state = smp_pkg::ms_reply;
				end else if (st_q.cmd == `SMP_OP_RUN) begin
					n.run = 1'b1;
					n.state = smp_pkg::ms_run;
				end
			end
			smp_pkg::ms_cap: begin
				if (!st_q.unlocked && st_q.mem_addr >= `SMP_FLASH_BASE) begin
					n.reply[15:8] = `SMP_INVALID_BYTE;
				end else begin
					n.reply[15:8] = mem_rdata;
				end
				n.two = 1'b0;
				n.state = smp_pkg::ms_reply;
			end
			smp_pkg::ms_reply: begin
				if (!st_q.tx_busy && !go) begin
					go = 1'b1;
					frame = {2'b11, st_q.reply[15:8], 1'b0, 2'b11};
					n.reply = {st_q.reply[7:0], 8'h00};
					n.two = 1'b0;
					if (!st_q.two) begin
						n.state = smp_pkg::ms_cmd;
					end
				end
			end
			default: begin
				n.state = smp_pkg::ms_latch;
			end
		endcase

		// transmitter: two released slots, start, data, stop
		if (st_q.tx_busy) begin
			if (st_q.tx_cnt != 9'h000) begin
				n.tx_cnt = st_q.tx_cnt - 9'h001;
			end else begin
				n.tx_cnt = div - 9'h001;
				if (st_q.tx_left == 4'h1) begin
					n.tx_busy = 1'b0;
				end else begin
					n.tx_left = st_q.tx_left - 4'h1;
					n.tx_sh = {1'b1, st_q.tx_sh[12:1]};
				end
			end
		end
		if (go) begin
			n.tx_busy = 1'b1;
			n.tx_cnt = div - 9'h001;
			n.tx_left = `SMP_TX_FRAME_SLOTS;
			n.tx_sh = frame;
		end

		if (system_reset) begin
			n.tx_busy = 1'b0;
			n.rx_busy = 1'b0;
			n.have = 1'b0;
			n.software_interrupt = st_q.forced;
			if (st_q.forced) begin
				n.state = st_q.sec_done ? smp_pkg::ms_brk : smp_pkg::ms_sec_rx;
			end else begin
				n.normal = 1'b0;
				n.state = smp_pkg::ms_latch;
			end
		end

		n.line_oe_n = !(n.tx_busy && !n.tx_sh[0]);
		st_d = n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.sec_ok <= 1'b1;
			st_q.irq_en <= `SMP_CTRL_RST;
			st_q.line_oe_n <= 1'b1;
			st_q.vec_page <= `SMP_USER_VEC_PAGE;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign serial_comm_pin_out = st_q.line_out;
	assign serial_comm_pin_oe_n = st_q.line_oe_n;
	assign mem_addr = st_q.mem_addr;
	assign mem_wdata = st_q.mem_wdata;
	assign mem_we = st_q.mem_we;
	assign mem_re = st_q.mem_re;
	assign watchdog_disable = st_q.wdog_dis;
	assign reset_capable_pin_is_reset = st_q.rst_pin;
	assign clock_capable_pin_is_clock = st_q.clk_pin;
	assign irq_branch_enable = st_q.br_en;
	assign port_a_bit2_zero = st_q.pa2_zero;
	assign vector_page = st_q.vec_page;
	assign extra_reset = st_q.extra_rst;
	assign illegal_addr_reset = st_q.illegal_rst;
	assign monitor_swi = st_q.software_interrupt;
	assign run_request = st_q.run;
	assign monitor_mode = st_q.normal || st_q.forced;
	assign forced_monitor = st_q.forced;
	assign flash_unlocked = st_q.unlocked;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_brk_in;
		st_q.rx_brk && !st_q.tx_busy;
	endsequence
	sequence s_brk_out;
		st_q.tx_busy && st_q.tx_sh[11:2] == 10'h000 && st_q.tx_sh[1:0] == 2'b11;
	endsequence

	property p_wdog_forced;
		st_q.forced |=> watchdog_disable;
	endproperty
	a_wdog_forced: assert property (p_wdog_forced) else $error("watchdog on in forced monitor");
	property p_wdog_normal;
		st_q.normal && !st_q.forced && high_test_voltage |=> watchdog_disable;
	endproperty
	a_wdog_normal: assert property (p_wdog_normal) else $error("watchdog on under test voltage");
	property p_pins_tv;
		st_q.normal && !st_q.forced && high_test_voltage |=> reset_capable_pin_is_reset && clock_capable_pin_is_clock;
	endproperty
	a_pins_tv: assert property (p_pins_tv) else $error("pin routing wrong under test voltage");
	property p_cfg_hold;
		st_q.normal && !st_q.forced && !st_q.wdog_dis && !high_test_voltage && !system_reset
			|=> $stable(reset_capable_pin_is_reset) && $stable(clock_capable_pin_is_clock);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("pin setup not frozen after voltage drop");
	property p_forced_pins;
		st_q.forced && !system_reset |=> irq_branch_enable && port_a_bit2_zero && !reset_capable_pin_is_reset;
	endproperty
	a_forced_pins: assert property (p_forced_pins) else $error("forced monitor pin setup wrong");
	property p_vec_page;
		(st_q.normal || st_q.forced) |=> vector_page == `SMP_MON_VEC_PAGE;
	endproperty
	a_vec_page: assert property (p_vec_page) else $error("monitor vectors not on page FE");
	property p_pause;
		$rose(st_q.tx_busy) |-> serial_comm_pin_oe_n [*8];
	endproperty
	a_pause: assert property (p_pause) else $error("line driven during pause");
	property p_brk_echo;
		s_brk_in |=> s_brk_out;
	endproperty
	a_brk_echo: assert property (p_brk_echo) else $error("break not echoed");
	property p_echo;
		st_q.rx_done && !st_q.tx_busy && !system_reset |=> st_q.tx_busy ##0 st_q.tx_sh[10:3] == $past(st_q.rx_sh[7:0]);
	endproperty
	a_echo: assert property (p_echo) else $error("byte not echoed");
	property p_cancel;
		st_q.state == smp_pkg::ms_wait && st_q.rx_brk && !system_reset |=> st_q.state == smp_pkg::ms_cmd ##1 !mem_we;
	endproperty
	a_cancel: assert property (p_cancel) else $error("break did not cancel command");
	property p_locked_read;
		st_q.state == smp_pkg::ms_cap && !st_q.unlocked && st_q.mem_addr >= `SMP_FLASH_BASE && !system_reset
			|=> st_q.reply[15:8] == `SMP_INVALID_BYTE;
	endproperty
	a_locked_read: assert property (p_locked_read) else $error("locked flash read leaked");
	property p_blank_vec;
		st_q.state == smp_pkg::ms_vec_lo && !st_q.normal && st_q.vhi == `SMP_ERASED
			&& mem_rdata == `SMP_ERASED && !system_reset |=> extra_reset && forced_monitor ##1 !extra_reset;
	endproperty
	a_blank_vec: assert property (p_blank_vec) else $error("blank vector not forced");

endmodule

// ---- bench/smp_host.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host end of the single-wire link
// ------------------------------------------------------------
module smp_host #(
	parameter int BIT = 256
) (
	// Bus clock and resolved wire level
	input wire logic pclk,
	input wire logic line,
	// High releases the wire
	output logic rel
);
	initial rel = 1'b1;
	// break: ten low bit times, then one released bit
	task automatic brk();
		rel <= 1'b0;
		repeat (BIT * 10) @(posedge pclk);
		rel <= 1'b1;
		repeat (BIT) @(posedge pclk);
	endtask
	task automatic send(input logic [7:0] b, input int idle);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		repeat (idle) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			rel <= f[i];
			repeat (BIT) @(posedge pclk);
		end
	endtask
	task automatic recv(output logic [8:0] v, output logic ok);
		int n;
		n = 0;
		while (line && n < 20 * BIT) begin
			@(posedge pclk);
			n++;
		end
		ok = !line;
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge pclk);
			v[i] = line;
		end
		// Stop slots end the echo; one more bit of quiet follows.
		repeat (BIT * 5 / 2) @(posedge pclk);
	endtask
endmodule

// ---- bench/tb_smp_monitor.sv ----
`timescale 1ns/1ps
`include "smp_regs.svh"
module tb_smp_monitor;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ok;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic so, soe_n, rel, line, htv, irq, msa, msb, cr, cc, srst, ff;
	logic [15:0] sp, ma, t;
	logic [8:0] v9;
	logic [7:0] wd, vp;
	logic [7:0] mem [0:65535];
	logic we, re, wdg, rp, cp, ib, pa2, xr, sx, mon, frc, unl;
	logic [7:0] tx_q[$];
	logic [8:0] rx_q[$];
	int n_fail = 0;
	int cmp_count = 0;
	int seed, n;

	assign line = (soe_n | so) & rel;

	smp_monitor smp_monitor_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_comm_pin_in(line), .serial_comm_pin_out(so), .serial_comm_pin_oe_n(soe_n),
		.high_test_voltage(htv), .irq_pin_level(irq), .mode_select_pin_a(msa), .mode_select_pin_b(msb),
		.cfg_reset_pin_en(cr), .cfg_clock_pin_en(cc), .system_reset(srst), .flash_fetch(ff),
		.cpu_sp(sp), .mem_addr(ma), .mem_wdata(wd), .mem_we(we), .mem_re(re), .mem_rdata(mem[ma]),
		.watchdog_disable(wdg), .reset_capable_pin_is_reset(rp), .clock_capable_pin_is_clock(cp),
		.irq_branch_enable(ib), .port_a_bit2_zero(pa2), .vector_page(vp), .extra_reset(xr),
		.illegal_addr_reset(), .monitor_swi(), .run_request(), .monitor_mode(mon),
		.forced_monitor(frc), .flash_unlocked(unl)
	);

	smp_host host_inst (.pclk(pclk), .line(line), .rel(rel));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (we) mem[ma] <= wd;
		if (xr) sx <= 1'b1;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Pready is taken at the rising edge, where the registered answer stands; release follows at that edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			n_fail++;
			end_sim();
		end
	endtask

	// Model: each sent byte returns as echo, then the queued replies follow.
	task automatic xfer();
		logic [8:0] v;
		foreach (tx_q[i]) begin
			host_inst.send(tx_q[i], $random(seed) & 63);
			host_inst.recv(v, ok);
			chk({ok, v}, {2'b11, tx_q[i]}); // echo check
			if (!ok) end_sim();
		end
		foreach (rx_q[i]) begin
			host_inst.recv(v, ok);
			chk({ok, v}, {1'b1, rx_q[i]}); // reply check
			if (!ok) end_sim();
		end
	endtask

	task automatic pulse_rst();
		srst <= 1'b1;
		@(posedge pclk);
		srst <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h64CADB8D;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{htv, irq, msa, msb, cr, cc, srst, ff, sx} = 9'h1C0;
		sp = 16'($random(seed));
		for (int i = 0; i < 65536; i++) mem[i] = 8'($random(seed));
		mem[16'hFFFE] = 8'h80;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (n = 0; n < 200 && !mon; n++) @(posedge pclk);
		if (!mon) begin
			n_fail++;
			end_sim();
		end
		msa <= 1'b0;
		msb <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({mon, frc, wdg, rp, cp, vp}, {5'h17, 8'hFE}); // entry
		apb(0, `SMP_STAT_OFF, 0);
		chk(r[3:0], 4'h1); // latched mode
		apb(1, `SMP_CTRL_OFF, 1);
		apb(0, `SMP_CTRL_OFF, 0);
		chk({e, r}, 1); // enable bit
		apb(0, 12'h008, 32'hFFFF);
		chk({e, r}, 40'h1_0000_0000);
		$display("test entry and registers finished");
		tx_q = {};
		for (int i = 0; i < 8; i++) tx_q.push_back(mem[16'(`SMP_SEC_BASE + i)]);
		rx_q = '{9'h000};
		xfer(); // security then break
		chk(unl, 1); // unlock flag
		$display("test security finished");
		t = sp + 16'h1;
		tx_q = '{`SMP_OP_READ_STACK_POINTER_CMD};
		rx_q = '{{1'b1, t[15:8]}, {1'b1, t[7:0]}};
		xfer(); // stack pointer
		tx_q = '{`SMP_OP_READ, 8'h90, 8'h00};
		rx_q = '{{1'b1, mem[16'h9000]}};
		xfer(); // flash read
		tx_q = '{`SMP_OP_READ_STACK_POINTER_CMD};
		rx_q = {};
		xfer();
		host_inst.brk();
		host_inst.recv(v9, ok);
		chk({ok, v9}, 10'h200); // break echoed
		if (!ok) end_sim();
		apb(0, `SMP_STAT_OFF, 0);
		chk(r[7:4], smp_pkg::ms_cmd); // break cancelled the command
		$display("test commands finished");
		cr <= 1'b1;
		@(posedge pclk);
		htv <= 1'b0;
		repeat (4) @(posedge pclk);
		cr <= 1'b0;
		cc <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({mon, wdg, rp, cp, ib}, 5'h15); // voltage lowered
		apb(1, `SMP_CTRL_OFF, 0);
		repeat (2) @(posedge pclk);
		chk(ib, 0); // enable cleared
		$display("test voltage lowered finished");
		mem[16'hFFFE] = 8'hFF;
		mem[16'hFFFF] = 8'hFF;
		msa <= 1'b0;
		msb <= 1'b0;
		pulse_rst();
		for (n = 0; n < 200 && !frc; n++) @(posedge pclk);
		if (!frc) begin
			n_fail++;
			end_sim();
		end
		repeat (2) @(posedge pclk);
		chk({sx, frc, wdg, pa2, ib, cp, rp, vp}, {7'h7E, 8'hFE}); // forced
		irq <= 1'b0;
		mem[16'hFFFE] = 8'h80;
		repeat (4) @(posedge pclk);
		chk({wdg, cp}, 2'h2); // pin low
		pulse_rst();
		repeat (40) @(posedge pclk);
		chk({frc, mon}, 2'h3); // stays forced
		$display("test forced mode finished");
		end_sim();
	end

	initial begin
		repeat (110000) @(posedge pclk);
		n_fail++;
		end_sim();
	end
endmodule
